/* core/oh_insert_pkg.sv */
// Package: constants and carrier types for the E3 transmit overhead insertion port
package oh_insert_pkg;
   // Overhead bit positions counted from the frame marker sample
   localparam int unsigned FAW_BITS       = 10;
   localparam logic [3:0]  POS_ALARM      = 4'hA;
   localparam logic [3:0]  POS_NATIONAL   = 4'hB;
   localparam logic [3:0]  POS_PARITY     = 4'hC;
   localparam logic [3:0]  POS_LAST       = 4'hF;
   localparam logic [9:0]  FAW_PATTERN    = 10'h3D0;
   // Overhead slot spacing in link clock periods; a small neutral default
   localparam logic [7:0]  OH_SPACING     = 8'h04;
   // Overhead clock divider: gap count at which the overhead clock falls
   localparam logic [1:0]  OH_CLK_HALF    = 2'h1;
   localparam logic [1:0]  SYNC_RESET     = 2'h0;
   localparam logic        OH_INIT        = 1'b0;

   typedef enum logic {
      METHOD_OH_CLOCK,
      METHOD_TX_CLOCK
   } method_type;

   // Insertable overhead values carried together
   typedef struct packed {
      logic alarm;
      logic national;
   } oh_bits_type;

   // Frame-side view of the overhead stream
   typedef struct packed {
      logic       valid;
      logic [3:0] pos;
      logic       bit_value;
   } oh_slot_type;
endpackage : oh_insert_pkg

/* core/edge_sync.sv */
// Two-stage synchroniser with edge detection behind the second stage
`timescale 1ns/100ps
module edge_sync (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic [1:0] sync_q;
   logic       last_q;

   // Only the second stage and later are read by logic
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync_q <= oh_insert_pkg::SYNC_RESET;
         last_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[0], async_in};
         last_q <= sync_q[1];
      end
   end

   assign level = sync_q[1];
   assign rise  = sync_q[1] & ~last_q;
   assign fall  = ~sync_q[1] & last_q;
endmodule : edge_sync

/* core/e3_tx_overhead_insert_port.sv */
// E3 transmit overhead insertion port: marker, strobe, overhead clock and bit capture
//
// Summary of operation
// - In local timing the transmit reference clock times all transmit logic.
// - Frame marker pulses high while the last frame bit is processed.
// - With insert enable high, sample overhead data on the selected method's edge.
// - With insert enable low, ignore overhead data and keep internal values.
// - Insert attempts on non-insertable bits are discarded.
// - Accepted bits go into the next outbound frame, not the current one.
// - Transmit-clock method samples on a reference clock edge (rising chosen).
// - Overhead-clock method samples on the falling edge of the overhead clock.
// - Device drives an overhead clock as the port's timing reference.
// - Two insertion methods; both parties use the same one.
// - Strobe high one reference period just before each overhead bit.
// - Counts 0-9 alignment, 10 alarm, 11 national, 12 on parity.
// - Alignment word is always 1111010000 regardless of insertion.
`timescale 1ns/100ps
module e3_tx_overhead_insert_port (
   input  wire logic                      mclk,
   input  wire logic                      rst_n,
   input  wire logic                      tx_timing_ref_clock,
   input  wire logic                      local_timing,
   input  wire oh_insert_pkg::method_type method_sel,
   input  wire logic                      oh_insert_enable,
   input  wire logic                      oh_serial_data_in,
   input  wire oh_insert_pkg::oh_bits_type internal_oh,
   output oh_insert_pkg::oh_slot_type     oh_slot_out,
   output logic                           oh_frame_marker,
   output logic                           oh_port_clock_out,
   output logic                           oh_bit_strobe
);
   ////////////////////////////////////////////////////////////////////
   logic ref_rise;
   logic ins_lvl, data_lvl;

   // Link clock and pins are sampled into mclk before anything reads them
   edge_sync u_ref (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .async_in (tx_timing_ref_clock),
      .level    (),
      .rise     (ref_rise),
      .fall     ()
   );

   logic [1:0] ins_sync_q, dat_sync_q;
   // Plain two-flop synchronisers for the far-end insert enable and data
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ins_sync_q <= oh_insert_pkg::SYNC_RESET;
         dat_sync_q <= oh_insert_pkg::SYNC_RESET;
      end else begin
         ins_sync_q <= {ins_sync_q[0], oh_insert_enable};
         dat_sync_q <= {dat_sync_q[0], oh_serial_data_in};
      end
   end
   assign ins_lvl  = ins_sync_q[1];
   assign data_lvl = dat_sync_q[1];

   ////////////////////////////////////////////////////////////////////
   // Transmit timing tick: frozen when local timing is off, so all transmit state holds
   logic tick;
   assign tick = local_timing & ref_rise;

   // Overhead slot sequencer: a gap counter between overhead bits
   logic [7:0] gap_q;
   logic [3:0] pos_q;
   logic       strobe_q;
   logic       bit_now;
   assign bit_now = tick && gap_q == oh_insert_pkg::OH_SPACING - 8'h01;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q <= 8'h00;
      end else if (tick) begin
         gap_q <= bit_now ? 8'h00 : gap_q + 8'h01;
      end
   end

   // Strobe covers the one reference period that precedes each overhead bit
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_q <= 1'b0;
      end else if (tick) begin
         strobe_q <= gap_q == oh_insert_pkg::OH_SPACING - 8'h02;
      end
   end
   assign oh_bit_strobe = strobe_q;

   // Position of the overhead bit now in process; wraps at frame end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pos_q <= oh_insert_pkg::POS_LAST;
      end else if (bit_now) begin
         pos_q <= pos_q + 4'h1;
      end
   end

   // Marker high while the last bit of the frame is processed
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         oh_frame_marker <= 1'b0;
      end else begin
         oh_frame_marker <= pos_q == oh_insert_pkg::POS_LAST;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Overhead clock: rises as each overhead bit starts and falls mid-bit, so the
   // far end's rising-edge count lines up with the position and capture sits mid-bit
   logic ohclk_fall;
   assign ohclk_fall = tick && gap_q == {6'h00, oh_insert_pkg::OH_CLK_HALF} && oh_port_clock_out;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         oh_port_clock_out <= 1'b0;
      end else if (bit_now) begin
         oh_port_clock_out <= 1'b1;
      end else if (ohclk_fall) begin
         oh_port_clock_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Capture edge depends on method; rising reference edge is taken for method 2
   logic sample_edge;
   always_comb begin
      unique case (method_sel)
         oh_insert_pkg::METHOD_OH_CLOCK: sample_edge = ohclk_fall;
         oh_insert_pkg::METHOD_TX_CLOCK: sample_edge = tick;
      endcase
   end

   function automatic logic insertable(input logic [3:0] p);
      insertable = p == oh_insert_pkg::POS_ALARM || p == oh_insert_pkg::POS_NATIONAL;
   endfunction

   // Pending values for the next frame; pending flags cleared at frame end
   oh_insert_pkg::oh_bits_type pend_q, cur_q;
   logic pend_a_q, pend_n_q;
   logic take;
   assign take = sample_edge & ins_lvl & insertable(pos_q);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q   <= '{oh_insert_pkg::OH_INIT, oh_insert_pkg::OH_INIT};
         pend_a_q <= 1'b0;
         pend_n_q <= 1'b0;
         cur_q    <= '{oh_insert_pkg::OH_INIT, oh_insert_pkg::OH_INIT};
      end else if (bit_now && pos_q == oh_insert_pkg::POS_LAST) begin
         // Frame boundary: pending inserts become current, internal values elsewhere
         cur_q.alarm    <= pend_a_q ? pend_q.alarm : internal_oh.alarm;
         cur_q.national <= pend_n_q ? pend_q.national : internal_oh.national;
         pend_a_q       <= 1'b0;
         pend_n_q       <= 1'b0;
      end else if (take) begin
         if (pos_q == oh_insert_pkg::POS_ALARM) begin
            pend_q.alarm <= data_lvl;
            pend_a_q     <= 1'b1;
         end else begin
            pend_q.national <= data_lvl;
            pend_n_q        <= 1'b1;
         end
      end
   end

   // Outgoing overhead stream: alignment word is fixed, parity left to the framer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         oh_slot_out <= '0;
      end else begin
         oh_slot_out.valid <= bit_now;
         oh_slot_out.pos   <= pos_q;
         if (pos_q < oh_insert_pkg::POS_ALARM) begin
            oh_slot_out.bit_value <= oh_insert_pkg::FAW_PATTERN[4'h9 - pos_q];
         end else if (pos_q == oh_insert_pkg::POS_ALARM) begin
            oh_slot_out.bit_value <= cur_q.alarm;
         end else if (pos_q == oh_insert_pkg::POS_NATIONAL) begin
            oh_slot_out.bit_value <= cur_q.national;
         end else begin
            oh_slot_out.bit_value <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   property p_marker_last;
      @(posedge mclk) disable iff (!rst_n) pos_q == oh_insert_pkg::POS_LAST |=> oh_frame_marker;
   endproperty
   a_marker_last: assert property (p_marker_last) else $error("marker missing at frame end");
   property p_no_take_low;
      @(posedge mclk) disable iff (!rst_n) !ins_lvl |-> !take;
   endproperty
   a_no_take_low: assert property (p_no_take_low) else $error("capture without insert enable");
   property p_non_ins;
      @(posedge mclk) disable iff (!rst_n) take |-> insertable(pos_q);
   endproperty
   a_non_ins: assert property (p_non_ins) else $error("non-insertable bit captured");
   property p_take_alarm;
      @(posedge mclk) disable iff (!rst_n)
         take && pos_q == oh_insert_pkg::POS_ALARM |=> pend_a_q && pend_q.alarm == $past(data_lvl);
   endproperty
   a_take_alarm: assert property (p_take_alarm) else $error("alarm insert not latched");
   property p_faw;
      @(posedge mclk) disable iff (!rst_n)
         pos_q == 4'h0 |=> oh_slot_out.bit_value;
   endproperty
   a_faw: assert property (p_faw) else $error("alignment word first bit wrong");
   property p_strobe_before;
      @(posedge mclk) disable iff (!rst_n) bit_now |-> strobe_q;
   endproperty
   a_strobe_before: assert property (p_strobe_before) else $error("strobe not ahead of bit");
   property p_frozen;
      @(posedge mclk) disable iff (!rst_n) !local_timing |=> $stable(gap_q);
   endproperty
   a_frozen: assert property (p_frozen) else $error("transmit ran without local timing");
   property p_next_frame;
      @(posedge mclk) disable iff (!rst_n) take |=> $stable(cur_q);
   endproperty
   a_next_frame: assert property (p_next_frame) else $error("insert hit current frame");
   property p_method1;
      @(posedge mclk) disable iff (!rst_n)
         method_sel == oh_insert_pkg::METHOD_OH_CLOCK && take |-> oh_port_clock_out ##1 !oh_port_clock_out;
   endproperty
   a_method1: assert property (p_method1) else $error("method 1 sampled off falling edge");
   c_take_alarm: cover property (@(posedge mclk) disable iff (!rst_n) take && pos_q == oh_insert_pkg::POS_ALARM);
   c_take_nat: cover property (@(posedge mclk) disable iff (!rst_n) take && pos_q == oh_insert_pkg::POS_NATIONAL);
   c_marker: cover property (@(posedge mclk) disable iff (!rst_n) oh_frame_marker);
endmodule : e3_tx_overhead_insert_port

/* testbench/oh_far_end_model.sv */
// Far-end terminal model: tracks overhead bits on the overhead clock and inserts alarm and national values
`timescale 1ns/100ps
module oh_far_end_model (
   input  wire logic       active,
   input  wire logic       oh_port_clock_out,
   input  wire logic       oh_frame_marker,
   input  wire logic [1:0] ins_bits,
   output logic            ins_en,
   output logic            ins_data
);
   logic [4:0] edge_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // Idle until the first marker is seen, so no stray insert goes out
   initial begin
      edge_cnt = 5'h1F;
      ins_en   = 1'b0;
      ins_data = 1'b0;
   end

   // Marker sampled high restarts the count; changes follow the rising edge
   always @(posedge oh_port_clock_out) begin
      edge_cnt = oh_frame_marker ? 5'h00 : ((edge_cnt == 5'h1F) ? edge_cnt : edge_cnt + 5'h01);
      if (active && (edge_cnt == 5'h0A || edge_cnt == 5'h0B)) begin
         ins_en   <= 1'b1;
         ins_data <= (edge_cnt == 5'h0A) ? ins_bits[1] : ins_bits[0];
      end else begin
         ins_en   <= 1'b0;
         ins_data <= ~ins_data; // Released data never shows the last value
      end
   end
endmodule : oh_far_end_model

/* testbench/testbench.sv */
// Self-checking bench for the overhead insertion port
`timescale 1ns/100ps
module testbench;
   logic                       mclk;
   logic                       rst_n;
   logic                       ref_clk;
   logic                       local_timing;
   oh_insert_pkg::method_type  method_sel;
   logic                       tb_en;
   logic                       tb_dat;
   logic                       p_act;
   logic [1:0]                 p_bits;
   wire logic                  p_en;
   wire logic                  p_dat;
   oh_insert_pkg::oh_bits_type internal_oh;
   oh_insert_pkg::oh_slot_type slot;
   logic                       marker;
   logic                       oh_clk;
   logic                       strobe;
   int                         fails;
   int                         compares;
   int                         cycles;
   wire logic                  ins_en;
   wire logic                  ins_dat;

   ////////////////////////////////////////////////////////////////////////////
   // Method 1 inputs come from the far-end model, method 2 from the bench
   assign ins_en  = (method_sel == oh_insert_pkg::METHOD_OH_CLOCK) ? p_en : tb_en;
   assign ins_dat = (method_sel == oh_insert_pkg::METHOD_OH_CLOCK) ? p_dat : tb_dat;

   e3_tx_overhead_insert_port dut_u (
      .mclk                (mclk),
      .rst_n               (rst_n),
      .tx_timing_ref_clock (ref_clk),
      .local_timing        (local_timing),
      .method_sel          (method_sel),
      .oh_insert_enable    (ins_en),
      .oh_serial_data_in   (ins_dat),
      .internal_oh         (internal_oh),
      .oh_slot_out         (slot),
      .oh_frame_marker     (marker),
      .oh_port_clock_out   (oh_clk),
      .oh_bit_strobe       (strobe)
   );

   oh_far_end_model far_u (
      .active            (p_act),
      .oh_port_clock_out (oh_clk),
      .oh_frame_marker   (marker),
      .ins_bits          (p_bits),
      .ins_en            (p_en),
      .ins_data          (p_dat)
   );

   ////////////////////////////////////////////////////////////////////////////
   // System clock, and a link clock with unrelated phase
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial begin
      ref_clk = 1'b0;
      #2.3;
      forever #40 ref_clk = ~ref_clk;
   end

   // Cuts a hang short; about eleven frames of work are expected
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Sampling on the falling edge keeps clear of the design's updates
   task automatic next_slot;
      int n;
      n = 0;
      @(negedge mclk);
      while (slot.valid !== 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 400) chk("slot_wait", 8'h00, 8'h01);
   endtask : next_slot

   // Checks one whole frame; optionally inserts, timed from the slot outputs it has just checked
   task automatic check_frame(input logic ea, input logic en, input logic ins, input logic ia, input logic in);
      int   k;
      logic e;
      k = 0;
      next_slot();
      while (slot.pos !== 4'h0 && k < 20) begin
         next_slot();
         k++;
      end
      for (int i = 0; i < 16; i++) begin
         if (i > 0) next_slot();
         e = (i < 10) ? oh_insert_pkg::FAW_PATTERN[9-i] : (i == 10) ? ea : (i == 11) ? en : 1'b0;
         chk("slot_pos", {4'h0, slot.pos}, i[7:0]);
         chk("slot_bit", {7'h00, slot.bit_value}, {7'h00, e});
         chk("frame_marker", {7'h00, marker}, {7'h00, i == 15});
         // Slot i has just ended, so the device is now working on position i+1
         @(posedge mclk);
         tb_en  <= ins && (i == 2 || i == 9 || i == 10 || i == 11);
         tb_dat <= !(ins && (i == 2 || i == 9 || i == 10 || i == 11)) ? ~tb_dat :
                   (i == 9) ? ia : (i == 10) ? in : (i == 11);
      end
      @(posedge mclk);
      tb_en <= 1'b0;
   endtask : check_frame

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_default;
      check_frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
   endtask : t_default

   // Insert in one frame, see it in the next only, then the framer's own again
   task automatic t_method2;
      check_frame(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      check_frame(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      check_frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
   endtask : t_method2

   task automatic t_method1;
      @(posedge mclk);
      method_sel <= oh_insert_pkg::METHOD_OH_CLOCK;
      p_act      <= 1'b1;
      repeat (20) next_slot();
      check_frame(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      p_act <= 1'b0;
      repeat (20) next_slot();
      check_frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
   endtask : t_method1

   // Ref period is 16 mclk; overhead clock is a quarter of the ref rate
   task automatic t_oh_clock;
      realtime t0;
      @(posedge oh_clk);
      t0 = $realtime;
      @(posedge oh_clk);
      chk("oh_clk_period", 8'(int'(($realtime - t0) / 5.0)), 8'h40);
      @(posedge strobe);
      t0 = $realtime;
      @(negedge strobe);
      chk("strobe_width", 8'(int'(($realtime - t0) / 5.0)), 8'h10);
      #1;
      chk("strobe_to_slot", {7'h00, slot.valid}, 8'h01);
   endtask : t_oh_clock

   // Without local timing nothing is sequenced
   task automatic t_freeze;
      int c;
      c = 0;
      @(posedge mclk);
      local_timing <= 1'b0;
      repeat (300) begin
         @(negedge mclk);
         if (slot.valid === 1'b1) c++;
      end
      chk("frozen_slots", c[7:0], 8'h00);
      @(posedge mclk);
      local_timing <= 1'b1;
   endtask : t_freeze

   task automatic give_verdict;
      if (fails == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      fails = 0;
      compares = 0;
      cycles = 0;
      rst_n = 1'b0;
      local_timing = 1'b1;
      method_sel = oh_insert_pkg::METHOD_TX_CLOCK;
      tb_en = 1'b0;
      tb_dat = 1'b0;
      p_act = 1'b0;
      p_bits = 2'h1;
      internal_oh = 2'h2;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (5) @(posedge mclk);
      t_default();
      t_oh_clock();
      t_method2();
      t_method1();
      t_freeze();
      give_verdict();
   end
endmodule : testbench
